// ### hdl/tcd_map.vh
// register map, field positions and reset values of the three-channel dma controller
`ifndef TCD_MAP_VH
`define TCD_MAP_VH
// byte offsets on apb
`define TCD_OFS_GLOBAL 8'h00
`define TCD_OFS_TRIGSEL 8'h04
`define TCD_OFS_CH_BASE 8'h10
`define TCD_OFS_CH_STRIDE 8'h10
`define TCD_OFS_CTL 4'h0
`define TCD_OFS_SRC 4'h4
`define TCD_OFS_DST 4'h8
`define TCD_OFS_SIZE 4'hC
// global control fields
`define TCD_G_FETCH 2
`define TCD_G_ROT 1
`define TCD_G_NMI 0
// channel control fields
`define TCD_C_MODE_HI 14
`define TCD_C_MODE_LO 12
`define TCD_C_DSTEP_HI 11
`define TCD_C_DSTEP_LO 10
`define TCD_C_SSTEP_HI 9
`define TCD_C_SSTEP_LO 8
`define TCD_C_DBYTE 7
`define TCD_C_SBYTE 6
`define TCD_C_LEVEL 5
`define TCD_C_EN 4
`define TCD_C_DONE 3
`define TCD_C_IE 2
`define TCD_C_ABORT 1
`define TCD_C_SWSTART 0
// step codes
`define TCD_STEP_DEC 2'h2
`define TCD_STEP_INC 2'h3
// reset values
`define TCD_RST_GLOBAL 3'h0
`define TCD_RST_CTL 15'h0000
`define TCD_RST_ADDR 20'h00000
`define TCD_RST_SIZE 16'h0000
`define TCD_RST_TRIGSEL 12'h000
`endif

// ### hdl/tcd_sync.v
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module tcd_sync
(
  // clock and reset
  input wire i_clock,
  input wire i_resetn,
  // level
  input wire i_level,
  output reg o_level
);
  reg meta_q;
  // first flop feeds only the second
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_q <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      meta_q <= i_level;
      o_level <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tcd_addr_step.v
// address stepping for one working address
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.vh"
module tcd_addr_step
(
  // stepping controls
  input wire [1:0] i_step,
  input wire i_byte,
  // address in and out
  input wire [19:0] i_addr,
  output reg [19:0] o_addr
);
  reg [19:0] amount;
  // byte steps by one, word by two
  always @*
  begin
    amount = i_byte ? 20'h00001 : 20'h00002;
    if (i_step == `TCD_STEP_INC)
      o_addr = i_addr + amount;
    else if (i_step == `TCD_STEP_DEC)
      o_addr = i_addr - amount;
    else
      o_addr = i_addr;
  end
endmodule
`default_nettype wire

// ### hdl/tcd_dma.v
// three-channel dma controller with apb registers and a simple memory master
// Operation
// - global control bits 31 to 3 read zero and ignore writes
// - fetch sync set: start at next instruction fetch, else immediately
// - fixed priority 0,1,2 or rotating priority after every transfer
// - nmi with abort enable: finish current move, stop, set abort flag
// - mode field: single, block, burst-block and repeated variants
// - destination steps by one or two; 10 decrements, 11 increments
// - only the working destination copy is stepped
// - source steps by one or two; 10 decrements, 11 increments
// - only the working source copy is stepped
// - destination width bit: 0 word, 1 byte
// - source width bit: 0 word, 1 byte
// - trigger sense: 0 rising edge, 1 high level
// - triggers and transfer starts only while channel enable is set; clearing it does not stop a block in flight
// - done flag and irq enable are software read and write
// - software start bit clears itself once the start is taken
// - addresses hold 20 bits, bits 31 to 20 read zero
// - a 16-bit source write clears address bits 19 to 16
// - a 16-bit destination write clears address bits 19 to 16
// - programmed source register never changes during blocks
// - size counter drops by one per moved unit
// - size counter reloads at once on reaching zero
// - size zero disables the channel; N moves N units per block
// - trigger select 0000 picks the software start bit
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.vh"
module tcd_dma
(
  // clock and reset
  input wire i_clock,
  input wire i_resetn,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // system events
  input wire [2:0] i_trigger,
  input wire i_nmi,
  input wire i_fetch,
  // memory master
  output reg o_mem_req,
  output reg o_mem_write,
  output reg [19:0] o_mem_addr,
  output reg o_mem_byte,
  output reg [15:0] o_mem_wdata,
  input wire i_mem_ack,
  input wire [15:0] i_mem_rdata,
  // done flags gated by enables
  output reg [2:0] o_chan_irq
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_READ = 2'h2;
  localparam ST_WRITE = 2'h3;

  reg [2:0] glob_q;
  reg [11:0] tsel_q;
  reg [14:0] ctl_q [0:2];
  reg [19:0] src_q [0:2];
  reg [19:0] dst_q [0:2];
  reg [15:0] size_q [0:2];
  reg [19:0] wsrc_q [0:2];
  reg [19:0] wdst_q [0:2];
  reg [15:0] cnt_q [0:2];
  reg [2:0] pend_q;
  reg [2:0] trig_prev_q;
  reg [1:0] state_q;
  reg [1:0] act_q;
  reg [1:0] top_q;
  reg [15:0] data_q;
  reg stop_q;
  wire [2:0] trig_s;
  wire [19:0] nsrc [0:2];
  wire [19:0] ndst [0:2];
  integer k;
  integer t;
  integer r;

  ////////////////////////////////////////////////////////////////////////////
  // triggers come from another block's timing, so synchronise them
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gch
      tcd_sync u_sync
      (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_level(i_trigger[g]),
        .o_level(trig_s[g])
      );
      tcd_addr_step u_src
      (
        .i_step(ctl_q[g][`TCD_C_SSTEP_HI:`TCD_C_SSTEP_LO]),
        .i_byte(ctl_q[g][`TCD_C_SBYTE]),
        .i_addr(wsrc_q[g]),
        .o_addr(nsrc[g])
      );
      tcd_addr_step u_dst
      (
        .i_step(ctl_q[g][`TCD_C_DSTEP_HI:`TCD_C_DSTEP_LO]),
        .i_byte(ctl_q[g][`TCD_C_DBYTE]),
        .i_addr(wdst_q[g]),
        .o_addr(ndst[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire acc = i_psel && i_penable;
  wire wr = acc && i_pwrite;
  wire in_ch = (i_paddr >= `TCD_OFS_CH_BASE) && (i_paddr < 8'h40);
  wire [7:0] choff = i_paddr - `TCD_OFS_CH_BASE;
  wire [1:0] ch_a = choff[5:4];
  wire [3:0] reg_a = choff[3:0];
  // a write with the upper half strobes off counts as a 16-bit access
  wire wide = i_pstrb[2];

  // trigger selection per channel; 0000 is the software bit, others map to the pin
  reg [2:0] hit;
  always @*
  begin
    hit = 3'h0;
    for (t = 0; t < 3; t = t + 1)
    begin
      if (tsel_q[t*4 +: 4] == 4'h0)
        hit[t] = ctl_q[t][`TCD_C_SWSTART];
      else if (ctl_q[t][`TCD_C_LEVEL])
        hit[t] = trig_s[t];
      else
        hit[t] = trig_s[t] & ~trig_prev_q[t];
      hit[t] = hit[t] && ctl_q[t][`TCD_C_EN] && (size_q[t] != 16'h0000);
    end
  end

  // pick a pending channel starting from the rotating top
  reg [1:0] pick;
  reg pick_ok;
  reg [1:0] cand;
  reg [2:0] sum;
  // three-bit sum so the wrap past channel 2 is not lost
  always @*
  begin
    pick = 2'h0;
    pick_ok = 1'b0;
    cand = 2'h0;
    sum = 3'h0;
    for (r = 2; r >= 0; r = r - 1)
    begin
      sum = {1'b0, top_q} + r[2:0];
      cand = (sum >= 3'h3) ? sum[1:0] - 2'h3 : sum[1:0];
      if (pend_q[cand] && ctl_q[cand][`TCD_C_EN])
      begin
        pick = cand;
        pick_ok = 1'b1;
      end
    end
  end

  wire [2:0] amode = ctl_q[act_q][`TCD_C_MODE_HI:`TCD_C_MODE_LO];
  wire last = (cnt_q[act_q] == 16'h0001);
  wire done_move = (state_q == ST_WRITE) && i_mem_ack;
  // block modes keep moving until the counter runs out
  wire more = amode[1:0] != 2'h0 && !last && !stop_q;

  ////////////////////////////////////////////////////////////////////////////
  // registers, transfer engine and bus answers
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      glob_q <= `TCD_RST_GLOBAL;
      tsel_q <= `TCD_RST_TRIGSEL;
      for (k = 0; k < 3; k = k + 1)
      begin
        ctl_q[k] <= `TCD_RST_CTL;
        src_q[k] <= `TCD_RST_ADDR;
        dst_q[k] <= `TCD_RST_ADDR;
        size_q[k] <= `TCD_RST_SIZE;
        wsrc_q[k] <= `TCD_RST_ADDR;
        wdst_q[k] <= `TCD_RST_ADDR;
        cnt_q[k] <= `TCD_RST_SIZE;
      end
      pend_q <= 3'h0;
      trig_prev_q <= 3'h0;
      state_q <= ST_IDLE;
      act_q <= 2'h0;
      top_q <= 2'h0;
      data_q <= 16'h0000;
      stop_q <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr <= 20'h00000;
      o_mem_byte <= 1'b0;
      o_mem_wdata <= 16'h0000;
      o_chan_irq <= 3'h0;
    end
    else
    begin
      trig_prev_q <= trig_s;
      // triggers latch as pending; the software start bit clears when taken
      for (k = 0; k < 3; k = k + 1)
      begin
        if (hit[k] && !stop_q)
        begin
          pend_q[k] <= 1'b1;
          ctl_q[k][`TCD_C_SWSTART] <= 1'b0;
        end
        else if (!ctl_q[k][`TCD_C_EN])
          pend_q[k] <= 1'b0;
        o_chan_irq[k] <= ctl_q[k][`TCD_C_DONE] & ctl_q[k][`TCD_C_IE];
      end
      // nmi stops further transfers; the move in flight completes
      if (glob_q[`TCD_G_NMI] && i_nmi && state_q != ST_IDLE)
        stop_q <= 1'b1;
      // apb: one wait state, answer in the access cycle after
      o_pready <= acc && !o_pready;
      o_pslverr <= 1'b0;
      if (acc && !o_pready)
      begin
        o_prdata <= 32'h00000000;
        if (i_paddr == `TCD_OFS_GLOBAL)
        begin
          o_prdata <= {29'h00000000, glob_q};
          if (wr)
            glob_q <= i_pwdata[2:0];
        end
        else if (i_paddr == `TCD_OFS_TRIGSEL)
        begin
          o_prdata <= {20'h00000, tsel_q};
          if (wr)
            tsel_q <= i_pwdata[11:0];
        end
        else if (in_ch && reg_a == `TCD_OFS_CTL)
        begin
          o_prdata <= {17'h00000, ctl_q[ch_a]};
          if (wr)
          begin
            ctl_q[ch_a] <= i_pwdata[14:0];
            // a start that lands on a write still clears the start bit
            if (hit[ch_a])
              ctl_q[ch_a][`TCD_C_SWSTART] <= 1'b0;
            if (done_move && act_q == ch_a && !more && last)
              ctl_q[ch_a][`TCD_C_DONE] <= 1'b1;
            if (done_move && act_q == ch_a && stop_q)
              ctl_q[ch_a][`TCD_C_ABORT] <= 1'b1;
          end
        end
        else if (in_ch && reg_a == `TCD_OFS_SRC)
        begin
          o_prdata <= {12'h000, src_q[ch_a]};
          if (wr)
            src_q[ch_a] <= wide ? i_pwdata[19:0] : {4'h0, i_pwdata[15:0]};
        end
        else if (in_ch && reg_a == `TCD_OFS_DST)
        begin
          o_prdata <= {12'h000, dst_q[ch_a]};
          if (wr)
            dst_q[ch_a] <= wide ? i_pwdata[19:0] : {4'h0, i_pwdata[15:0]};
        end
        else if (in_ch && reg_a == `TCD_OFS_SIZE)
        begin
          o_prdata <= {16'h0000, size_q[ch_a]};
          if (wr)
          begin
            size_q[ch_a] <= i_pwdata[15:0];
            cnt_q[ch_a] <= i_pwdata[15:0];
            wsrc_q[ch_a] <= src_q[ch_a];
            wdst_q[ch_a] <= dst_q[ch_a];
          end
        end
        else
          o_pslverr <= 1'b1;
      end
      // transfer engine
      case (state_q)
        ST_IDLE:
        begin
          if (pick_ok && !stop_q)
          begin
            act_q <= pick;
            pend_q[pick] <= 1'b0;
            state_q <= glob_q[`TCD_G_FETCH] ? ST_WAIT : ST_READ;
            if (cnt_q[pick] == size_q[pick])
            begin
              wsrc_q[pick] <= src_q[pick];
              wdst_q[pick] <= dst_q[pick];
            end
          end
        end
        ST_WAIT:
        begin
          if (i_fetch)
            state_q <= ST_READ;
        end
        ST_READ:
        begin
          o_mem_req <= 1'b1;
          o_mem_write <= 1'b0;
          o_mem_addr <= wsrc_q[act_q];
          o_mem_byte <= ctl_q[act_q][`TCD_C_SBYTE];
          if (o_mem_req && i_mem_ack)
          begin
            o_mem_req <= 1'b0;
            data_q <= i_mem_rdata;
            state_q <= ST_WRITE;
          end
        end
        default:
        begin
          o_mem_req <= !i_mem_ack;
          o_mem_write <= 1'b1;
          o_mem_addr <= wdst_q[act_q];
          o_mem_byte <= ctl_q[act_q][`TCD_C_DBYTE];
          o_mem_wdata <= ctl_q[act_q][`TCD_C_SBYTE] ? {8'h00, data_q[7:0]} : data_q;
          if (o_mem_req && i_mem_ack)
          begin
            wsrc_q[act_q] <= nsrc[act_q];
            wdst_q[act_q] <= ndst[act_q];
            cnt_q[act_q] <= cnt_q[act_q] - 16'h0001;
            if (glob_q[`TCD_G_ROT])
              top_q <= (act_q == 2'h2) ? 2'h0 : act_q + 2'h1;
            else
              top_q <= 2'h0;
            if (last)
            begin
              cnt_q[act_q] <= size_q[act_q];
              ctl_q[act_q][`TCD_C_DONE] <= 1'b1;
              wsrc_q[act_q] <= src_q[act_q];
              wdst_q[act_q] <= dst_q[act_q];
              if (!amode[2])
                ctl_q[act_q][`TCD_C_EN] <= 1'b0;
            end
            if (stop_q)
            begin
              ctl_q[act_q][`TCD_C_ABORT] <= 1'b1;
              state_q <= ST_IDLE;
            end
            else if (more)
              state_q <= ST_READ;
            else
              state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verification/tcd_mem_model.sv
// memory and peripheral model answering the dma master port
`timescale 1ns/1ps
`default_nettype none
module tcd_mem_model
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // master side
  input wire logic i_mem_req,
  input wire logic i_mem_write,
  input wire logic [19:0] i_mem_addr,
  input wire logic i_mem_byte,
  input wire logic [15:0] i_mem_wdata,
  output logic o_mem_ack,
  output logic [15:0] o_mem_rdata
);
  logic [19:0] wa[$];
  logic [15:0] wd[$];
  logic wb[$];
  int stall;
  //////////////////////////////////////////////////////////////////////
  // random stalls; read data toggles outside the ack cycle so stale data shows
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= 16'h0000;
      stall <= 0;
    end
    else if (i_mem_req && !o_mem_ack && stall == 0)
    begin
      o_mem_ack <= 1'b1;
      o_mem_rdata <= {2{i_mem_addr[7:0] ^ 8'h5A}}; // both lanes equal
      stall <= $urandom % 3;
      if (i_mem_write)
      begin
        wa.push_back(i_mem_addr);
        wd.push_back(i_mem_wdata);
        wb.push_back(i_mem_byte);
      end
    end
    else
    begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      if (stall != 0)
        stall <= stall - 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/tcd_dma_sva.sv
// protocol and register checks for the dma controller ports
`timescale 1ns/1ps
`default_nettype none
module tcd_dma_sva
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // memory master
  input wire logic o_mem_req,
  input wire logic o_mem_write,
  input wire logic [19:0] o_mem_addr,
  input wire logic i_mem_ack
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire acc = i_psel && i_penable && !o_pready;
  // a unit is read first, then written
  sequence read_done_s;
    o_mem_req && !o_mem_write && i_mem_ack;
  endsequence
  sequence write_next_s;
    !o_mem_req ##[1:4] (o_mem_req && o_mem_write);
  endsequence
  //////////////////////////////////////////////////////////////////////
  apb_wait_a: assert property (acc |=> o_pready)
    else $error("apb answer late");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (acc && i_paddr >= 8'h40 |=> o_pslverr)
    else $error("unmapped access accepted");
  global_zero_a: assert property (acc && !i_pwrite && i_paddr == 8'h00 |=> o_prdata[31:3] == 29'h0)
    else $error("global upper bits set");
  addr_upper_a: assert property (acc && !i_pwrite && i_paddr inside {8'h14, 8'h18, 8'h24, 8'h28, 8'h34, 8'h38}
    |=> o_prdata[31:20] == 12'h000)
    else $error("address upper bits set");
  req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_write))
    else $error("memory request dropped early");
  read_write_a: assert property (read_done_s |=> write_next_s)
    else $error("read not followed by write");
  reset_quiet_a: assert property ($rose(i_resetn) |-> !o_mem_req && !o_pready)
    else $error("outputs busy after reset");
endmodule
bind tcd_dma tcd_dma_sva i_tcd_dma_sva (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr),
  .i_mem_ack(i_mem_ack));
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the three-channel dma controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rstn, psel, pen, pwr, fetch, nmi, ack, req, mwr, mbyte, rdy, err, rerr;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [2:0] trig, irq;
  logic [19:0] maddr, sa, da, sa0, da0;
  logic [15:0] mwd, mrd, sz;
  logic [1:0] ch, w;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n0;
  tcd_dma i_tcd_dma (.i_clock(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(rdy), .o_pslverr(err),
    .i_trigger(trig), .i_nmi(nmi), .i_fetch(fetch), .o_mem_req(req), .o_mem_write(mwr), .o_mem_addr(maddr),
    .o_mem_byte(mbyte), .o_mem_wdata(mwd), .i_mem_ack(ack), .i_mem_rdata(mrd), .o_chan_irq(irq));
  tcd_mem_model i_tcd_mem_model (.i_clock(clk), .i_resetn(rstn), .i_mem_req(req), .i_mem_write(mwr),
    .i_mem_addr(maddr), .i_mem_byte(mbyte), .i_mem_wdata(mwd), .o_mem_ack(ack), .o_mem_rdata(mrd));
  //////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; an idle edge first so psel is never driven twice at one edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    // no wait limit here: only the bench timeout ends a hung transfer
    do @(posedge clk); while (rdy !== 1'b1);
    rdata = prdata;
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, rdata, e);
  endtask
  function automatic int nlog();
    nlog = i_tcd_mem_model.wa.size();
  endfunction
  // waits for the log to grow, bounded
  task automatic waitn(input int n, input int lim);
    for (int k = 0; k < lim && nlog() < n; k++) @(posedge clk);
  endtask
  function automatic logic [19:0] step(input logic [19:0] a, input logic [1:0] c, input logic by);
    step = c == 2'h3 ? a + (by ? 20'h1 : 20'h2) : c == 2'h2 ? a - (by ? 20'h1 : 20'h2) : a;
  endfunction
  function automatic logic [31:0] ctlv(input logic [2:0] md, input logic [3:0] st, input logic [1:0] wd,
    input logic [5:0] lo);
    ctlv = {17'h0, md, st, wd, lo};
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, psel, pen, pwr, fetch, nmi, trig, paddr, pwdata, pstrb} = '0;
    void'($urandom(32'hF7DF05E7));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rdc("global reset", 8'h00, 32'h0);
    rdc("control reset", 8'h20, 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    rdc("global bits", 8'h00, 32'h7);
    wr(8'h00, 32'h0);
    apb(1'b0, 8'h40, 32'h0, 4'h0);
    chk("unmapped error", rerr, 1'b1);
    for (b = 8'h14; b < 8'h1C; b += 8'h4)
    begin
      wr(b, 32'hFFFF_FFFF);
      rdc("address bits", b, 32'h000F_FFFF);
      apb(1'b1, b, 32'hFFFF_FFFF, 4'h3);
      rdc("word write", b, 32'h0000_FFFF);
    end
    $display("done: registers");
    // every mode and step code, random channel and widths
    for (int i = 0; i < 8; i++)
    begin
      ch = 2'($urandom % 3);
      w = 2'($urandom);
      sz = i % 4 == 0 ? 16'h1 : 16'(1 + $urandom % 4);
      sa = {12'h1, 7'($urandom), 1'b0};
      da = {12'h3, 7'($urandom), 1'b0};
      sa0 = sa;
      da0 = da;
      b = {2'b00, ch + 2'h1, 4'h0};
      n0 = nlog();
      wr(b + 8'h4, {12'h0, sa});
      wr(b + 8'h8, {12'h0, da});
      wr(b + 8'hC, {16'h0, sz});
      wr(b, ctlv(i[2:0], {i[1:0], ~i[1:0]}, w, 6'h15));
      waitn(n0 + sz + 1, 400);
      chk("moves", nlog() - n0, sz);
      for (int k = 0; k < sz; k++)
      begin
        chk("dest address", i_tcd_mem_model.wa[n0 + k], da);
        chk("moved data", i_tcd_mem_model.wd[n0 + k][7:0], sa[7:0] ^ 8'h5A);
        chk("dest width", i_tcd_mem_model.wb[n0 + k], w[1]);
        sa = step(sa, ~i[1:0], w[0]);
        da = step(da, i[1:0], w[1]);
      end
      rdc("source reg", b + 8'h4, {12'h0, sa0});
      rdc("dest reg", b + 8'h8, {12'h0, da0});
      rdc("size reload", b + 8'hC, {16'h0, sz});
      rdc("control", b, ctlv(i[2:0], {i[1:0], ~i[1:0]}, w, {1'b0, i[2], 4'hC}));
      chk("irq line", irq[ch], 1'b1);
      wr(b, 32'h0);
      rdc("flag cleared", b, 32'h0);
    end
    $display("done: modes");
    // size zero, then a disabled channel
    n0 = nlog();
    wr(8'h1C, 32'h0);
    wr(8'h10, ctlv(3'h1, 4'hF, 2'h0, 6'h11));
    waitn(n0 + 1, 40);
    wr(8'h10, ctlv(3'h1, 4'hF, 2'h0, 6'h01));
    wr(8'h1C, 32'h2);
    waitn(n0 + 1, 40);
    chk("no moves", nlog() - n0, 0);
    // hardware trigger on channel 2: edge, then level
    wr(8'h04, 32'h100);
    wr(8'h3C, 32'h2);
    n0 = nlog();
    wr(8'h30, ctlv(3'h0, 4'h0, 2'h0, 6'h10));
    trig <= 3'h4;
    waitn(n0 + 2, 60);
    chk("edge moves", nlog() - n0, 1);
    wr(8'h30, ctlv(3'h0, 4'h0, 2'h0, 6'h30));
    waitn(n0 + 3, 60);
    chk("level moves", nlog() - n0, 2);
    trig <= 3'h0;
    $display("done: triggers");
    // fetch sync: a software start waits for the next fetch pulse
    wr(8'h00, 32'h4);
    n0 = nlog();
    wr(8'h10, ctlv(3'h0, 4'h0, 2'h0, 6'h11));
    repeat (20) @(posedge clk);
    chk("fetch wait", nlog() - n0, 0);
    fetch <= 1'b1;
    @(posedge clk);
    fetch <= 1'b0;
    waitn(n0 + 2, 40);
    chk("fetch start", nlog() - n0, 1);
    wr(8'h00, 32'h0);
    $display("done: fetch");
    // three level triggers at once: fixed order, then rotating order
    wr(8'h04, 32'h111);
    for (int r = 0; r < 2; r++)
    begin
      wr(8'h00, r * 2);
      for (int c = 0; c < 3; c++)
      begin
        b = 8'(16 * c + 16);
        wr(b + 8'h8, {12'h7, 6'h0, 2'(c)});
        wr(b + 8'hC, 32'h2);
        wr(b, ctlv(3'h0, 4'h0, 2'h0, 6'h30));
      end
      n0 = nlog();
      trig <= 3'h7;
      waitn(n0 + 7, 200);
      trig <= 3'h0;
      chk("priority moves", nlog() - n0, 6);
      for (int k = 0; k < 6; k++)
        chk("priority order", i_tcd_mem_model.wa[n0 + k], {12'h7, 6'h0, 2'(r ? k % 3 : k / 2)});
    end
    wr(8'h04, 32'h0);
    $display("done: priority");
    // nmi in mid-block stops the channel
    wr(8'h00, 32'h1);
    wr(8'h1C, 32'h4);
    n0 = nlog();
    wr(8'h10, ctlv(3'h1, 4'hF, 2'h0, 6'h11));
    waitn(n0 + 1, 100);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    waitn(n0 + 4, 80);
    chk("abort stops", nlog() - n0 < 4, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 4'h0);
    chk("abort flag", rdata[1], 1'b1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc("control after reset", 8'h10, 32'h0);
    $display("done: abort");
    tally_and_finish();
  end
endmodule
`default_nettype wire
